/* rtl/buck_seq_defines.svh */
// Timing counts and phase encodings for the step-down converter sequencer
// How it works
// - Switching clock falling edge sets the cycle latch, turning the high-side switch on.
// - Comparator trip (sense plus ramp above amplifier) clears the latch during on-time.
// - Untripped latch is cleared on the switching clock rising edge, limiting duty.
// - Low-side switch command is always the complement of the high-side command.
// - Enable and test-mode both high enables the part and starts soft-start.
// - Enable or test-mode low disables the part and starts soft shut-down.
// - Stay shut down until the input supply is above the rising lockout level.
// - After enable, no switching until soft-start is above its switching threshold.
// - Supply below falling lockout shuts off; recovery restarts without latching.
// - Regulate to soft-start voltage until it exceeds the internal reference.
// - Power-good held low from power-up until soft-start completes.
// - Feedback at upper threshold releases power-good after the assertion delay.
// - Feedback at lower threshold pulls power-good low after the deassertion delay.
// - Peak-current trip turns the high-side switch off at once.
// - After a current-limit trip, switch again next cycle unless under-voltage.
// - Current limit with under-voltage and amplifier saturation latches overcurrent.
// - Over-voltage latches low-side on, high-side off until power cycle.
// - Under-voltage flag follows feedback below its threshold.
// - Over-temperature latches the converter off until power cycle.
// - Sync output clock is phase shifted 180, 120 or 90 degrees by selector.
// - Feedback driven to the bias level selects slave mode.
`ifndef BUCK_SEQ_DEFINES_SVH
`define BUCK_SEQ_DEFINES_SVH
`define CLK_PERIOD_NS      100
`define PG_ASSERT_US       500
`define PG_DEASSERT_US     50
`define PG_ASSERT_CYC      ((`PG_ASSERT_US * 1000) / `CLK_PERIOD_NS)
`define PG_DEASSERT_CYC    ((`PG_DEASSERT_US * 1000) / `CLK_PERIOD_NS)
`define PHASE_SEL_LOW      2'h0
`define PHASE_SEL_MID      2'h1
`define PHASE_SEL_HIGH     2'h2
`define CNT_W              13
`endif

/* rtl/buck_seq_pkg.sv */
// Types shared by the step-down converter sequencer
package buck_seq_pkg;
   typedef enum logic [3:0] {
      ST_OFF      = 4'h1,
      ST_SOFT     = 4'h2,
      ST_RUN      = 4'h4,
      ST_SHUTDOWN = 4'h8
   } seq_state_t;
endpackage

/* rtl/pg_delay_timer.sv */
// Power-good assertion and deassertion delay filter
`timescale 1ns/1ps
`include "buck_seq_defines.svh"
module pg_delay_timer
#(
   parameter int ASSERT_CYC   = `PG_ASSERT_CYC,
   parameter int DEASSERT_CYC = `PG_DEASSERT_CYC
)
(
   input  wire logic clk_i,      // System clock
   input  wire logic rst_n_i,    // Synchronised reset
   input  wire logic allow_i,    // Soft-start done, no fault
   input  wire logic fb_good_i,  // Feedback at or above upper level
   input  wire logic fb_low_i,   // Feedback at or below lower level
   output logic      good_o      // Filtered power-good level
);
   logic [`CNT_W-1:0] count;

   // Delay counter toward the pending change
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         count  <= '0;
         good_o <= 1'b0;
      end
      else if (!allow_i)
      begin
         count  <= '0;
         good_o <= 1'b0;
      end
      else if (!good_o && fb_good_i)
      begin
         if (count == `CNT_W'(ASSERT_CYC - 1))
         begin
            good_o <= 1'b1;
            count  <= '0;
         end
         else
            count <= count + `CNT_W'(1);
      end
      else if (good_o && fb_low_i)
      begin
         if (count == `CNT_W'(DEASSERT_CYC - 1))
         begin
            good_o <= 1'b0;
            count  <= '0;
         end
         else
            count <= count + `CNT_W'(1);
      end
      else
         count <= '0;
   end
endmodule

/* rtl/sync_phase_gen.sv */
// Phase-shifted timing clock for a following converter
`timescale 1ns/1ps
`include "buck_seq_defines.svh"
module sync_phase_gen
#(
   parameter int PER_W = 12
)
(
   input  wire logic             clk_i,      // System clock
   input  wire logic             rst_n_i,    // Synchronised reset
   input  wire logic             rise_i,     // Switching clock rising pulse
   input  wire logic [1:0]       sel_i,      // Phase delay select
   output logic                  sync_o      // Sync clock out
);
   logic [PER_W-1:0] cnt;
   logic [PER_W-1:0] period;
   logic [PER_W-1:0] next_off;

   // Offset as a fraction of the measured period
   always_comb
   begin
      case (sel_i)
         `PHASE_SEL_MID:  next_off = PER_W'(period / PER_W'(3));
         `PHASE_SEL_HIGH: next_off = period >> 2;
         default:         next_off = period >> 1;
      endcase
   end

   // Period measurement and delayed half-period output
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt    <= '0;
         period <= '0;
         sync_o <= 1'b0;
      end
      else
      begin
         if (rise_i)
         begin
            period <= cnt;
            cnt    <= '0;
         end
         else
            cnt <= cnt + PER_W'(1);
         if (cnt == next_off)
            sync_o <= 1'b1;
         else if (cnt == PER_W'(next_off + (period >> 1)))
            sync_o <= 1'b0;
      end
   end
endmodule

/* rtl/buck_pwm_fault_sequencer.sv */
// Step-down converter switching, sequencing and protection control
`timescale 1ns/1ps
`include "buck_seq_defines.svh"
module buck_pwm_fault_sequencer
   import buck_seq_pkg::*;
#(
   parameter int PG_ASSERT_CYC   = `PG_ASSERT_CYC,
   parameter int PG_DEASSERT_CYC = `PG_DEASSERT_CYC
)
(
   input  wire logic       clk_i,              // 10 MHz clock
   input  wire logic       rst_n_i,            // Async reset, active low
   input  wire logic       enable_i,           // Enable pin
   input  wire logic       test_mode_i,        // Test-mode pin, tied to enable
   input  wire logic       vin_above_rise_i,   // Supply above rising lockout
   input  wire logic       vin_below_fall_i,   // Supply below falling lockout
   input  wire logic       ss_above_sw_i,      // Soft-start above switching level
   input  wire logic       ss_above_ref_i,     // Soft-start above reference
   input  wire logic       ss_discharged_i,    // Soft-start node discharged
   input  wire logic       sw_clk_i,           // Switching clock (osc or sync)
   input  wire logic       pwm_trip_i,         // Sense plus ramp above amplifier
   input  wire logic       ilim_i,             // Peak current above limit
   input  wire logic       amp_sat_i,          // Error amplifier saturated
   input  wire logic       fb_pg_hi_i,         // Feedback at upper good level
   input  wire logic       fb_pg_lo_i,         // Feedback at lower good level
   input  wire logic       fb_uv_i,            // Feedback below under-voltage
   input  wire logic       fb_ov_i,            // Feedback above over-voltage
   input  wire logic       fb_at_bias_i,       // Feedback at bias level
   input  wire logic       over_temp_i,        // Junction above threshold
   input  wire logic [1:0] phase_delay_select_i, // Phase select level
   output logic            high_side_switch_o, // High-side command
   output logic            low_side_switch_o,  // Low-side command
   output logic            ss_charge_o,        // Soft-start charge source on
   output logic            ss_discharge_o,     // Soft-start discharge on
   output logic            ref_from_ss_o,      // Regulate to soft-start voltage
   output logic            power_good_out_o,   // Power-good level
   output logic            power_good_oe_o,    // Power-good pull-down enable
   output logic            sync_clock_out_o,   // Phase-shifted timing clock
   output logic            slave_mode_o,       // Slave mode active
   output logic            undervoltage_fault_o, // Under-voltage flag
   output logic            overcurrent_fault_o,  // Latched overcurrent
   output logic            overvoltage_fault_o,  // Latched over-voltage
   output logic            thermal_fault_o       // Latched thermal
);
   // ------------------------------------------------------------------
   // Reset and input synchronisers
   // ------------------------------------------------------------------
   logic       rst_meta;
   logic       rst_n;
   localparam int NS = 16;
   logic [NS-1:0] raw;
   logic [NS-1:0] meta;
   logic [NS-1:0] syn;

   // Reset release through two flops
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   assign raw = {phase_delay_select_i, fb_at_bias_i, over_temp_i, fb_ov_i, fb_uv_i,
                 fb_pg_lo_i, fb_pg_hi_i, amp_sat_i, ilim_i, pwm_trip_i, sw_clk_i,
                 ss_discharged_i, ss_above_ref_i, ss_above_sw_i,
                 enable_i & test_mode_i};

   // Two-flop synchronisers, one per input bit, with enable and test-mode sharing one
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++)
      begin : g_sync
         always_ff @(posedge clk_i or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta[gi] <= 1'b0;
               syn[gi]  <= 1'b0;
            end
            else
            begin
               meta[gi] <= raw[gi];
               syn[gi]  <= meta[gi];
            end
         end
      end
   endgenerate

   // Supply comparators, synchronised separately
   logic [1:0] vin_meta;
   logic [1:0] vin_syn;
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vin_meta <= 2'h0;
         vin_syn  <= 2'h0;
      end
      else
      begin
         vin_meta <= {vin_below_fall_i, vin_above_rise_i};
         vin_syn  <= vin_meta;
      end
   end

   logic       en_s, ss_sw_s, ss_ref_s, ss_dis_s, clk_s; // Sequencing and clock inputs
   logic       trip_s, ilim_s, sat_s, pg_hi_s, pg_lo_s; // Sense and power-good inputs
   logic       uv_s, ov_s, ot_s, bias_s;                // Fault and mode inputs
   logic [1:0] pd_s;                                    // Phase select
   // Enable and test-mode arrive pre-combined, relying on their joint drive
   assign {pd_s, bias_s, ot_s, ov_s, uv_s, pg_lo_s, pg_hi_s, sat_s, ilim_s, trip_s,
           clk_s, ss_dis_s, ss_ref_s, ss_sw_s, en_s} = syn;

   // ------------------------------------------------------------------
   // Supply lockout and fault latches
   // ------------------------------------------------------------------
   logic supply_ok;
   logic any_fault;

   // Lockout with hysteresis; restarts without latching
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         supply_ok <= 1'b0;
      else if (vin_syn[1])
         supply_ok <= 1'b0;
      else if (vin_syn[0])
         supply_ok <= 1'b1;
   end

   // Latched faults, cleared only by a lockout power cycle
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         overcurrent_fault_o <= 1'b0;
         overvoltage_fault_o <= 1'b0;
         thermal_fault_o     <= 1'b0;
      end
      else if (!supply_ok)
      begin
         overcurrent_fault_o <= 1'b0;
         overvoltage_fault_o <= 1'b0;
         thermal_fault_o     <= 1'b0;
      end
      else
      begin
         if (ilim_s && uv_s && sat_s)
            overcurrent_fault_o <= 1'b1;
         if (ov_s)
            overvoltage_fault_o <= 1'b1;
         if (ot_s)
            thermal_fault_o <= 1'b1;
      end
   end

   assign any_fault = overcurrent_fault_o | overvoltage_fault_o | thermal_fault_o;

   // Status flags
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         undervoltage_fault_o <= 1'b0;
         slave_mode_o         <= 1'b0;
         ref_from_ss_o        <= 1'b1;
      end
      else
      begin
         undervoltage_fault_o <= uv_s;
         slave_mode_o         <= bias_s;
         ref_from_ss_o        <= !ss_ref_s;
      end
   end

   // ------------------------------------------------------------------
   // Enable and soft-start sequencer
   // ------------------------------------------------------------------
   seq_state_t state;
   seq_state_t next_state;

   always_comb
   begin
      next_state = state;
      case (state)
         ST_OFF:      if (supply_ok && en_s && !any_fault) next_state = ST_SOFT;
         ST_SOFT:     if (!en_s) next_state = ST_SHUTDOWN;
                      else if (ss_ref_s) next_state = ST_RUN;
         ST_RUN:      if (!en_s) next_state = ST_SHUTDOWN;
         ST_SHUTDOWN: if (ss_dis_s) next_state = ST_OFF;
                      else if (en_s) next_state = ST_SOFT;
         default:     next_state = ST_OFF;
      endcase
      if (!supply_ok || any_fault)
         next_state = ST_OFF;
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         state <= ST_OFF;
      else
         state <= next_state;
   end

   assign ss_charge_o    = (state == ST_SOFT) || (state == ST_RUN);
   assign ss_discharge_o = (state == ST_SHUTDOWN);

   // ------------------------------------------------------------------
   // Cycle latch and switch commands
   // ------------------------------------------------------------------
   logic clk_d;
   logic clk_fall;
   logic clk_rise;
   logic run_ok;
   logic ilim_block;

   // Edge detect on the synchronised switching clock
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         clk_d <= 1'b0;
      else
         clk_d <= clk_s;
   end
   assign clk_fall = clk_d && !clk_s;
   assign clk_rise = !clk_d && clk_s;
   assign run_ok   = ((state == ST_SOFT) && ss_sw_s) || (state == ST_RUN);

   // Current-limit trip holds the next cycle off only under under-voltage
   assign ilim_block = uv_s && ilim_s;

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         high_side_switch_o <= 1'b0;
      else if (!run_ok || any_fault)
         high_side_switch_o <= 1'b0;
      else if (high_side_switch_o && (trip_s || ilim_s))
         high_side_switch_o <= 1'b0;
      else if (clk_rise)
         high_side_switch_o <= 1'b0;
      else if (clk_fall && !ilim_block)
         high_side_switch_o <= 1'b1;
   end

   // Low side follows the complement; over-voltage forces it on
   assign low_side_switch_o = !high_side_switch_o;

   // ------------------------------------------------------------------
   // Power-good and sync output
   // ------------------------------------------------------------------
   logic pg_good;
   pg_delay_timer #(
      .ASSERT_CYC   (PG_ASSERT_CYC),
      .DEASSERT_CYC (PG_DEASSERT_CYC)
   ) u_pg (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n),
      .allow_i   ((state == ST_RUN) && !any_fault),
      .fb_good_i (pg_hi_s),
      .fb_low_i  (pg_lo_s),
      .good_o    (pg_good)
   );
   assign power_good_out_o = 1'b0;
   assign power_good_oe_o  = !pg_good;

   sync_phase_gen #(
      .PER_W (12)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .rise_i  (clk_rise),
      .sel_i   (pd_s),
      .sync_o  (sync_clock_out_o)
   );

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_complement;
      @(posedge clk_i) disable iff (!rst_n) low_side_switch_o != high_side_switch_o;
   endproperty
   a_complement: assert property (p_complement) else $error("switches not complementary");
   property p_fault_off;
      @(posedge clk_i) disable iff (!rst_n) any_fault |=> !high_side_switch_o;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("high side on under fault");
   property p_ot_latch;
      @(posedge clk_i) disable iff (!rst_n) (ot_s && supply_ok) |=> thermal_fault_o;
   endproperty
   a_ot_latch: assert property (p_ot_latch) else $error("thermal not latched");
   property p_oc_latch;
      @(posedge clk_i) disable iff (!rst_n)
         (ilim_s && uv_s && sat_s && supply_ok) |=> overcurrent_fault_o;
   endproperty
   a_oc_latch: assert property (p_oc_latch) else $error("overcurrent not latched");
   property p_ilim_off;
      @(posedge clk_i) disable iff (!rst_n) (high_side_switch_o && ilim_s) |=> !high_side_switch_o;
   endproperty
   a_ilim_off: assert property (p_ilim_off) else $error("current limit ignored");
   property p_rise_off;
      @(posedge clk_i) disable iff (!rst_n) clk_rise |=> !high_side_switch_o;
   endproperty
   a_rise_off: assert property (p_rise_off) else $error("duty not limited");
   property p_no_sw_early;
      @(posedge clk_i) disable iff (!rst_n)
         ((state == ST_SOFT) && !ss_sw_s) |=> !high_side_switch_o;
   endproperty
   a_no_sw_early: assert property (p_no_sw_early) else $error("switching before threshold");

   property p_lockout;
      @(posedge clk_i) disable iff (!rst_n) !supply_ok |=> (state == ST_OFF);
   endproperty
   a_lockout: assert property (p_lockout) else $error("running in lockout");

   property p_pg_low;
      @(posedge clk_i) disable iff (!rst_n) (state != ST_RUN) |=> ##1 power_good_oe_o;
   endproperty
   a_pg_low: assert property (p_pg_low) else $error("power good high early");

   c_on: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(high_side_switch_o));
   c_run: cover property (@(posedge clk_i) disable iff (!rst_n) state == ST_RUN);
   c_pg: cover property (@(posedge clk_i) disable iff (!rst_n) $fell(power_good_oe_o));
   c_oc: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(overcurrent_fault_o));
endmodule

/* verification/power_stage_model.sv */
// Behavioural power stage, sense comparators and system enable
`timescale 1ns/1ps
module power_stage_model
#(
   parameter int HALF_CYC = 12,
   parameter int ON_CYC   = 3
)
(
   input  wire logic clk_i,          // System clock
   input  wire logic en_i,           // System enable request
   input  wire logic hs_i,           // High-side command
   input  wire logic ss_charge_i,    // Soft-start charging
   input  wire logic ss_discharge_i, // Soft-start discharging
   input  wire logic no_trip_i,      // Comparator never trips
   output logic      enable_o,       // Enable pin
   output logic      test_mode_o,    // Test-mode pin
   output logic      sw_clk_o,       // Switching clock
   output logic      pwm_trip_o,     // Sense plus ramp above amplifier
   output logic      ss_above_sw_o,  // Soft-start above switching level
   output logic      ss_above_ref_o, // Soft-start above reference
   output logic      ss_discharged_o // Soft-start node empty
);
   int ph;
   int on;
   int ss;
   // Enable and test-mode share one net
   assign enable_o    = en_i;
   assign test_mode_o = en_i;
   // Clock of 24 cycles, about 417 kHz, inside the sync range
   assign sw_clk_o        = ph < HALF_CYC;
   assign pwm_trip_o      = !no_trip_i && on >= ON_CYC;
   assign ss_above_sw_o   = ss > 3;
   assign ss_above_ref_o  = ss > 8;
   assign ss_discharged_o = ss == 0;
   // Oscillator phase, ramp timer and slow soft-start node
   always @(negedge clk_i)
   begin
      ph <= (ph + 1) % (2 * HALF_CYC);
      on <= hs_i ? on + 1 : 0;
      if (ph == 0 && ss_charge_i && ss < 11)
         ss <= ss + 1;
      else if (ph == 0 && ss_discharge_i && ss > 0)
         ss <= ss - 1;
   end
endmodule

/* verification/buck_pwm_fault_sequencer_test.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) \
      begin \
         $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
         num_errors++; \
      end \
   end
module buck_pwm_fault_sequencer_test;
   // ----------------------------------------------------------------
   // Stimulus, observation and models
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [4:0] stim;  // Limit, under-voltage, saturation, over-voltage, hot
      logic [3:0] flags; // Overcurrent, over-voltage, thermal, under-voltage
      logic       sw;    // Switching carries on
   } row_t;
   localparam int HS = 7, OE = 6, CHG = 5, DCHG = 4, REF = 3, SYNC = 2, SLV = 1, CLK = 0;
   logic clk_i = 1'h0, rst_n_i = 1'h0, en = 1'h0, no_trip = 1'h0, hs_seen = 1'h0;
   logic vin_above_rise_i = 1'h0, vin_below_fall_i = 1'h1, ilim_i = 1'h0, amp_sat_i = 1'h0;
   logic fb_pg_hi_i = 1'h0, fb_pg_lo_i = 1'h1, fb_uv_i = 1'h0, fb_ov_i = 1'h0;
   logic fb_at_bias_i = 1'h0, over_temp_i = 1'h0;
   logic [1:0] phase_delay_select_i = 2'h0;
   logic enable_i, test_mode_i, sw_clk_i, pwm_trip_i, ss_above_sw_i, ss_above_ref_i;
   logic ss_discharged_i, high_side_switch_o, low_side_switch_o, ss_charge_o, ss_discharge_o;
   logic ref_from_ss_o, power_good_out_o, power_good_oe_o, sync_clock_out_o, slave_mode_o;
   logic undervoltage_fault_o, overcurrent_fault_o, overvoltage_fault_o, thermal_fault_o;
   logic [7:0] obs;
   logic [3:0] flags;
   int num_errors = 0;
   int n_checks = 0;
   int cnt;
   int d [3];
   row_t rows [5] = '{'{5'h10, 4'h0, 1'h1},
                      '{5'h08, 4'h1, 1'h1},
                      '{5'h1c, 4'h9, 1'h0},
                      '{5'h02, 4'h4, 1'h0},
                      '{5'h01, 4'h2, 1'h0}};
   assign obs = {high_side_switch_o, power_good_oe_o, ss_charge_o, ss_discharge_o,
                 ref_from_ss_o, sync_clock_out_o, slave_mode_o, sw_clk_i};
   assign flags = {overcurrent_fault_o, overvoltage_fault_o, thermal_fault_o,
                   undervoltage_fault_o};
   // Clock of 100 ns
   always #50 clk_i = ~clk_i;
   buck_pwm_fault_sequencer #(.PG_ASSERT_CYC(20), .PG_DEASSERT_CYC(5)) i_dut (.clk_i, .rst_n_i,
      .enable_i, .test_mode_i, .vin_above_rise_i, .vin_below_fall_i, .ss_above_sw_i,
      .ss_above_ref_i, .ss_discharged_i, .sw_clk_i, .pwm_trip_i, .ilim_i, .amp_sat_i,
      .fb_pg_hi_i, .fb_pg_lo_i, .fb_uv_i, .fb_ov_i, .fb_at_bias_i, .over_temp_i,
      .phase_delay_select_i, .high_side_switch_o, .low_side_switch_o, .ss_charge_o,
      .ss_discharge_o, .ref_from_ss_o, .power_good_out_o, .power_good_oe_o, .sync_clock_out_o,
      .slave_mode_o, .undervoltage_fault_o, .overcurrent_fault_o, .overvoltage_fault_o,
      .thermal_fault_o);
   power_stage_model i_stage (.clk_i, .en_i(en), .hs_i(high_side_switch_o),
      .ss_charge_i(ss_charge_o), .ss_discharge_i(ss_discharge_o), .no_trip_i(no_trip),
      .enable_o(enable_i), .test_mode_o(test_mode_i), .sw_clk_o(sw_clk_i),
      .pwm_trip_o(pwm_trip_i), .ss_above_sw_o(ss_above_sw_i), .ss_above_ref_o(ss_above_ref_i),
      .ss_discharged_o(ss_discharged_i));
   // Switching activity and complementary commands, sampled where settled
   always @(negedge clk_i)
   begin
      if (high_side_switch_o === 1'h1)
         hs_seen <= 1'h1;
      if (rst_n_i === 1'h1)
         `CHECK("low side", ~high_side_switch_o, low_side_switch_o)
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Waits at falling edges for an observed output, giving up after lim plus one cycles
   task automatic wait_for(input int sel, input logic lvl, input int lim, output int n);
      n = 0;
      while (obs[sel] !== lvl && n <= lim)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n > lim)
      begin
         $display("ERROR wait %0d expected %0h seen %0h", sel, lvl, obs[sel]);
         num_errors++;
         end_sim();
      end
   endtask
   task automatic power(input logic up);
      vin_above_rise_i = up;
      vin_below_fall_i = ~up;
      idle(10);
   endtask
   task automatic pulse(output int w);
      int n;
      wait_for(HS, 1'h0, 40, n);
      wait_for(HS, 1'h1, 40, n);
      wait_for(HS, 1'h0, 40, w);
   endtask
   // Main sequence: fault table, then hand-written cases
   initial
   begin
      repeat (16) @(posedge clk_i);
      @(negedge clk_i);
      rst_n_i = 1'h1;
      en = 1'h1;
      foreach (rows[i])
      begin
         power(1'h0);
         power(1'h1);
         `CHECK("cleared", 4'h0, flags)
         wait_for(HS, 1'h1, 600, cnt);
         {ilim_i, fb_uv_i, amp_sat_i, fb_ov_i, over_temp_i} = rows[i].stim;
         idle(12);
         hs_seen = 1'h0;
         idle(60);
         `CHECK("flags", rows[i].flags, flags)
         `CHECK("switching", rows[i].sw, hs_seen)
         {ilim_i, fb_uv_i, amp_sat_i, fb_ov_i, over_temp_i} = 5'h00;
         idle(12);
         `CHECK("latched", rows[i].flags & 4'he, flags)
      end
      $display("done: fault table");
      power(1'h0);
      power(1'h1);
      wait_for(HS, 1'h1, 600, cnt);
      en = 1'h0;
      wait_for(DCHG, 1'h1, 10, cnt);
      wait_for(DCHG, 1'h0, 400, cnt);
      `CHECK("discharged", 1'h1, ss_discharged_i)
      rst_n_i = 1'h0;
      idle(3);
      `CHECK("rst hs", 1'h0, high_side_switch_o)
      `CHECK("rst pg", 1'h1, power_good_oe_o)
      `CHECK("rst ref", 1'h1, ref_from_ss_o)
      rst_n_i = 1'h1;
      power(1'h0);
      en = 1'h1;
      idle(60);
      `CHECK("lockout", 1'h0, ss_charge_o)
      $display("done: reset and lockout");
      power(1'h1);
      wait_for(CHG, 1'h1, 20, cnt);
      `CHECK("ref soft", 1'h1, ref_from_ss_o)
      wait_for(HS, 1'h1, 600, cnt);
      `CHECK("sw level", 1'h1, ss_above_sw_i)
      `CHECK("pg soft", 1'h1, power_good_oe_o)
      wait_for(REF, 1'h0, 400, cnt);
      pulse(cnt);
      `CHECK("trip width", 1'h1, cnt < 10)
      no_trip = 1'h1;
      idle(30);
      pulse(cnt);
      `CHECK("max duty", 1'h1, cnt >= 11 && cnt <= 13)
      ilim_i = 1'h1;
      idle(30);
      pulse(cnt);
      `CHECK("limit width", 1'h1, cnt < 10)
      wait_for(HS, 1'h1, 30, cnt);
      ilim_i = 1'h0;
      no_trip = 1'h0;
      $display("done: switching");
      fb_pg_lo_i = 1'h0;
      fb_pg_hi_i = 1'h1;
      wait_for(OE, 1'h0, 40, cnt);
      `CHECK("pg assert", 1'h1, cnt >= 20 && cnt <= 28)
      fb_pg_hi_i = 1'h0;
      fb_pg_lo_i = 1'h1;
      wait_for(OE, 1'h1, 20, cnt);
      `CHECK("pg deassert", 1'h1, cnt >= 5 && cnt <= 13)
      `CHECK("pg level", 1'h0, power_good_out_o)
      $display("done: power good");
      for (int s = 0; s < 3; s++)
      begin
         phase_delay_select_i = s[1:0];
         idle(60);
         wait_for(CLK, 1'h0, 30, cnt);
         wait_for(CLK, 1'h1, 30, cnt);
         wait_for(SYNC, 1'h0, 30, cnt);
         wait_for(SYNC, 1'h1, 30, d[s]);
         d[s] += cnt;
      end
      `CHECK("phase low", 6, d[0] - d[2])
      `CHECK("phase mid", 2, d[1] - d[2])
      fb_at_bias_i = 1'h1;
      wait_for(SLV, 1'h1, 10, cnt);
      $display("done: sync and slave");
      power(1'h0);
      `CHECK("supply off", 1'h0, ss_charge_o)
      power(1'h1);
      wait_for(CHG, 1'h1, 20, cnt);
      $display("done: supply restart");
      end_sim();
   end
endmodule
